// file: nau_dec_if.sv
// decode carrier between the unit core and its instruction decoder
// assumes one instruction word in, decoded fields out, no clock
`default_nettype none

interface nau_dec_if;
    import nau_pkg::*;
    logic [15:0] instr;
    nau_kind_e kind;
    logic [6:0] addr;
    logic [3:0] imm;
    logic imm_form;
    logic use_cin;
    logic keep_carry;
    logic writeback;
    logic known;
    modport dec (input instr, output kind, addr, imm, imm_form, use_cin, keep_carry, writeback,
        known);
    modport core (output instr, input kind, addr, imm, imm_form, use_cin, keep_carry, writeback,
        known);
endinterface

`default_nettype wire

// file: nau_decoder.sv
// instruction decoder for the addition group
// assumes a stable instruction word from the core; purely combinational
`default_nettype none
`include "nau_defs.svh"

module nau_decoder (
    nau_dec_if.dec dif
);
    import nau_pkg::*;

    logic [7:0] opc;
    logic mem_ok;

    always_comb
    begin
        opc = dif.instr[`NAU_OPC_HI:`NAU_OPC_LO];
        mem_ok = !dif.instr[`NAU_ADDR_PAD_BIT];
        dif.kind = K_NONE;
        case (opc)
            `NAU_OP_CIN_MEM_LOAD: dif.kind = mem_ok ? K_CIN_MEM_LOAD : K_NONE;
            `NAU_OP_CIN_IMM_LOAD: dif.kind = K_CIN_IMM_LOAD;
            `NAU_OP_CIN_MEM_WB: dif.kind = mem_ok ? K_CIN_MEM_WB : K_NONE;
            `NAU_OP_CIN_IMM_WB: dif.kind = K_CIN_IMM_WB;
            `NAU_OP_PLAIN_MEM_LOAD: dif.kind = mem_ok ? K_PLAIN_MEM_LOAD : K_NONE;
            `NAU_OP_PLAIN_IMM_LOAD: dif.kind = K_PLAIN_IMM_LOAD;
            `NAU_OP_PLAIN_MEM_WB: dif.kind = mem_ok ? K_PLAIN_MEM_WB : K_NONE;
            `NAU_OP_PLAIN_IMM_WB: dif.kind = K_PLAIN_IMM_WB;
            `NAU_OP_KEEPC_MEM_LOAD: dif.kind = mem_ok ? K_KEEPC_MEM_LOAD : K_NONE;
            default: dif.kind = K_NONE;
        endcase
        dif.known = (dif.kind != K_NONE);
        dif.imm_form = (dif.kind == K_CIN_IMM_LOAD) || (dif.kind == K_CIN_IMM_WB)
            || (dif.kind == K_PLAIN_IMM_LOAD) || (dif.kind == K_PLAIN_IMM_WB);
        dif.use_cin = (dif.kind == K_CIN_MEM_LOAD) || (dif.kind == K_CIN_IMM_LOAD)
            || (dif.kind == K_CIN_MEM_WB) || (dif.kind == K_CIN_IMM_WB);
        dif.keep_carry = (dif.kind == K_KEEPC_MEM_LOAD);
        dif.writeback = (dif.kind == K_CIN_MEM_WB) || (dif.kind == K_CIN_IMM_WB)
            || (dif.kind == K_PLAIN_MEM_WB) || (dif.kind == K_PLAIN_IMM_WB);
        // immediate field and working register selector
        dif.imm = dif.instr[`NAU_IMM_HI:`NAU_IMM_LO];
        if (dif.imm_form)
        begin
            dif.addr = `NAU_WR_BASE
                + {3'h0, dif.instr[`NAU_WSEL_HI:`NAU_WSEL_LO]};
        end
        else
        begin
            dif.addr = dif.instr[`NAU_ADDR_HI:`NAU_ADDR_LO];
        end
    end
endmodule

`default_nettype wire

// file: nau_defs.svh
// constants for the nibble addition unit: opcodes, fields, reset values
// assumes inclusion by the modules of this unit and by the testbench only
`ifndef NAU_DEFS_SVH
`define NAU_DEFS_SVH

// opcode byte, instruction bits 15..8
`define NAU_OP_CIN_MEM_LOAD 8'h10
`define NAU_OP_CIN_IMM_LOAD 8'h0C
`define NAU_OP_CIN_MEM_WB 8'h09
`define NAU_OP_CIN_IMM_WB 8'h0D
`define NAU_OP_PLAIN_MEM_LOAD 8'h18
`define NAU_OP_PLAIN_IMM_LOAD 8'h1C
`define NAU_OP_PLAIN_MEM_WB 8'h19
`define NAU_OP_PLAIN_IMM_WB 8'h1D
`define NAU_OP_KEEPC_MEM_LOAD 8'h28

// instruction field positions
`define NAU_OPC_HI 15
`define NAU_OPC_LO 8
`define NAU_IMM_HI 7
`define NAU_IMM_LO 4
`define NAU_WSEL_HI 3
`define NAU_WSEL_LO 0
`define NAU_ADDR_HI 6
`define NAU_ADDR_LO 0
`define NAU_ADDR_PAD_BIT 7

// data ram address of working register 0
`define NAU_WR_BASE 7'h00

// reset values
`define NAU_ACC_RST 4'h0
`define NAU_CF_RST 1'b0
`define NAU_ZF_RST 1'b0
`define NAU_INSTR_RST 16'h0000
`define NAU_ADDR_RST 7'h00

`endif

// file: nau_pkg.sv
// types shared by the nibble addition unit
// assumes nothing beyond a systemverilog compiler
`default_nettype none

package nau_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC, ST_FINISH} nau_state_e;
    typedef enum logic [3:0] {
        K_NONE,
        K_CIN_MEM_LOAD,
        K_CIN_IMM_LOAD,
        K_CIN_MEM_WB,
        K_CIN_IMM_WB,
        K_PLAIN_MEM_LOAD,
        K_PLAIN_IMM_LOAD,
        K_PLAIN_MEM_WB,
        K_PLAIN_IMM_WB,
        K_KEEPC_MEM_LOAD
    } nau_kind_e;
endpackage

`default_nettype wire

// file: nau_ram_model.sv
// data ram model for the nibble addition unit: 128 nibbles, synchronous read
// assumes one clock; read data is valid only in the cycle after a read request
`default_nettype none

module nau_ram_model (
    input wire logic clk_sys,
    input wire logic [6:0] ram_addr,
    input wire logic ram_rd_en,
    output logic [3:0] ram_rdata,
    input wire logic ram_wr_en,
    input wire logic [3:0] ram_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] mem [0:127];

    initial
    begin
        ram_rdata = 4'h0;
    end

    // read data held one cycle, then inverted each cycle, so a stale value shows only every other cycle
    always @(posedge clk_sys)
    begin
        if (ram_rd_en)
            ram_rdata <= mem[ram_addr];
        else
            ram_rdata <= ~ram_rdata;
        if (ram_wr_en)
            mem[ram_addr] <= ram_wdata;
    end
endmodule

`default_nettype wire

// file: nau_unit.sv
// nibble addition unit: decode and execute of the binary addition group
// assumes fetch logic and a synchronous-read data ram on clk_sys
// Overview of operation
// - carry-in memory load: acc gets mem plus acc plus carry; carry, zero updated
// - carry-in immediate load: acc gets working reg plus imm plus carry; flags updated
// - carry-in memory write-back: sum to acc and memory; carry, zero updated
// - carry-in immediate write-back: sum to acc and working reg; flags updated
// - plain memory load: acc gets mem plus acc; carry, zero updated
// - plain immediate load: acc gets working reg plus imm; register untouched
// - plain memory write-back: sum to acc and memory; carry, zero updated
// - plain immediate write-back: sum to acc and working reg; flags updated
// - carry-keeping memory load: acc gets mem plus acc; only zero updated
// - immediate from bits 7..4, working register selector from bits 3..0
// - memory address from bits 6..0, used for read and write-back
`default_nettype none
`include "nau_defs.svh"

module nau_unit (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    output logic instr_ready,
    output logic [6:0] ram_addr,
    output logic ram_rd_en,
    input wire logic [3:0] ram_rdata,
    output logic ram_wr_en,
    output logic [3:0] ram_wdata,
    output logic [3:0] result_nibble_register,
    output logic carry_flag,
    output logic zero_flag,
    output logic exec_done
);
    import nau_pkg::*;

    nau_dec_if dif ();

    nau_decoder u_dec (
        .dif(dif)
    );

    nau_state_e state_reg;
    nau_state_e state_next;
    logic [15:0] instr_reg;
    logic [15:0] instr_next;
    logic ready_reg;
    logic ready_next;
    logic [6:0] addr_reg;
    logic [6:0] addr_next;
    logic rd_en_reg;
    logic rd_en_next;
    logic wr_en_reg;
    logic wr_en_next;
    logic [3:0] wdata_reg;
    logic [3:0] wdata_next;
    logic [3:0] acc_reg;
    logic [3:0] acc_next;
    logic cf_reg;
    logic cf_next;
    logic zf_reg;
    logic zf_next;
    logic done_reg;
    logic done_next;
    logic [4:0] sum;
    logic [3:0] operand_b;

    // four-bit add with carry out in bit 4
    function automatic logic [4:0] nau_add(input logic [3:0] a, input logic [3:0] b,
        input logic cin);
        nau_add = {1'b0, a} + {1'b0, b} + {4'h0, cin};
    endfunction

    // decoder sees the incoming word while idle, the held word otherwise
    assign dif.instr = (state_reg == ST_IDLE) ? instr_word : instr_reg;

    always_comb
    begin
        operand_b = dif.imm_form ? dif.imm : acc_reg;
        sum = nau_add(ram_rdata, operand_b, dif.use_cin ? cf_reg : 1'b0);
        state_next = state_reg;
        instr_next = instr_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        acc_next = acc_reg;
        cf_next = cf_reg;
        zf_next = zf_reg;
        wr_en_next = 1'b0;
        done_next = 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                // unknown words are taken and dropped
                if (instr_valid && dif.known)
                begin
                    instr_next = instr_word;
                    addr_next = dif.addr;
                    state_next = ST_READ;
                end
            end
            ST_READ:
            begin
                state_next = ST_EXEC;
            end
            ST_EXEC:
            begin
                // operand arrives from ram in this cycle
                acc_next = sum[3:0];
                zf_next = (sum[3:0] == 4'h0);
                if (!dif.keep_carry)
                begin
                    cf_next = sum[4];
                end
                wr_en_next = dif.writeback;
                wdata_next = sum[3:0];
                done_next = 1'b1;
                state_next = ST_FINISH;
            end
            ST_FINISH:
            begin
                state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
        ready_next = (state_next == ST_IDLE);
        rd_en_next = (state_next == ST_READ);
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_IDLE;
            instr_reg <= `NAU_INSTR_RST;
            ready_reg <= 1'b1;
            addr_reg <= `NAU_ADDR_RST;
            rd_en_reg <= 1'b0;
            wr_en_reg <= 1'b0;
            wdata_reg <= `NAU_ACC_RST;
            acc_reg <= `NAU_ACC_RST;
            cf_reg <= `NAU_CF_RST;
            zf_reg <= `NAU_ZF_RST;
            done_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            instr_reg <= instr_next;
            ready_reg <= ready_next;
            addr_reg <= addr_next;
            rd_en_reg <= rd_en_next;
            wr_en_reg <= wr_en_next;
            wdata_reg <= wdata_next;
            acc_reg <= acc_next;
            cf_reg <= cf_next;
            zf_reg <= zf_next;
            done_reg <= done_next;
        end
    end

    assign instr_ready = ready_reg;
    assign ram_addr = addr_reg;
    assign ram_rd_en = rd_en_reg;
    assign ram_wr_en = wr_en_reg;
    assign ram_wdata = wdata_reg;
    assign result_nibble_register = acc_reg;
    assign carry_flag = cf_reg;
    assign zero_flag = zf_reg;
    assign exec_done = done_reg;

    // checks of the executed result against the operands of the exec cycle
    a_cin_mem_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_reg == ST_EXEC && dif.kind == K_CIN_MEM_LOAD) |=>
            ({cf_reg, acc_reg} == nau_add($past(ram_rdata), $past(acc_reg), $past(cf_reg)))
            && !wr_en_reg && done_reg)
        else $error("carry-in memory load result wrong");

    a_cin_imm_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_reg == ST_EXEC && dif.kind == K_CIN_IMM_LOAD) |=>
            ({cf_reg, acc_reg} == nau_add($past(ram_rdata), $past(instr_reg[7:4]),
            $past(cf_reg))) && !wr_en_reg)
        else $error("carry-in immediate load result wrong");

    a_cin_mem_wb: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_reg == ST_EXEC && dif.kind == K_CIN_MEM_WB) |=>
            ({cf_reg, acc_reg} == nau_add($past(ram_rdata), $past(acc_reg), $past(cf_reg)))
            && wr_en_reg && ram_wdata == acc_reg)
        else $error("carry-in memory write-back wrong");

    a_cin_imm_wb: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_reg == ST_EXEC && dif.kind == K_CIN_IMM_WB) |=>
            ({cf_reg, acc_reg} == nau_add($past(ram_rdata), $past(instr_reg[7:4]),
            $past(cf_reg))) && wr_en_reg && ram_wdata == acc_reg)
        else $error("carry-in immediate write-back wrong");

    a_plain_mem_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_reg == ST_EXEC && dif.kind == K_PLAIN_MEM_LOAD) |=>
            ({cf_reg, acc_reg} == nau_add($past(ram_rdata), $past(acc_reg), 1'b0))
            && !wr_en_reg)
        else $error("plain memory load result wrong");

    a_plain_imm_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_reg == ST_EXEC && dif.kind == K_PLAIN_IMM_LOAD) |=>
            ({cf_reg, acc_reg} == nau_add($past(ram_rdata), $past(instr_reg[7:4]), 1'b0))
            && !wr_en_reg ##1 !wr_en_reg)
        else $error("plain immediate load wrong or register written");

    a_plain_mem_wb: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_reg == ST_EXEC && dif.kind == K_PLAIN_MEM_WB) |=>
            ({cf_reg, acc_reg} == nau_add($past(ram_rdata), $past(acc_reg), 1'b0))
            && wr_en_reg && ram_wdata == acc_reg)
        else $error("plain memory write-back wrong");

    a_plain_imm_wb: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_reg == ST_EXEC && dif.kind == K_PLAIN_IMM_WB) |=>
            ({cf_reg, acc_reg} == nau_add($past(ram_rdata), $past(instr_reg[7:4]), 1'b0))
            && wr_en_reg && ram_wdata == acc_reg)
        else $error("plain immediate write-back wrong");

    a_keep_carry: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_reg == ST_EXEC && dif.kind == K_KEEPC_MEM_LOAD) |=>
            ({1'b0, acc_reg} == (nau_add($past(ram_rdata), $past(acc_reg), 1'b0) & 5'h0F))
            && cf_reg == $past(cf_reg) && !wr_en_reg)
        else $error("carry-keeping add changed carry or result wrong");

    a_imm_fields: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_reg == ST_IDLE && instr_valid && dif.imm_form) |=>
            ram_rd_en && ram_addr == `NAU_WR_BASE + {3'h0, $past(instr_word[3:0])}
            ##1 dif.imm == $past(instr_word[7:4], 2))
        else $error("immediate form fields decoded wrong");

    a_mem_address: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_reg == ST_IDLE && instr_valid && dif.known && !dif.imm_form) |=>
            ram_rd_en && ram_addr == $past(instr_word[6:0])
            ##2 ram_addr == $past(instr_word[6:0], 3))
        else $error("memory address not held from read to write-back");

    a_zero_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
        exec_done |-> zero_flag == (result_nibble_register == 4'h0))
        else $error("zero flag disagrees with result");

    a_exec_timing: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (instr_ready && instr_valid && dif.known) |=>
            !instr_ready ##2 exec_done ##1 instr_ready && !exec_done)
        else $error("execution sequence timing wrong");

    a_wr_only_done: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ram_wr_en |-> exec_done && !ram_rd_en)
        else $error("memory write outside completion cycle");

    a_rd_one_shot: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ram_rd_en |=> !ram_rd_en && ram_addr == $past(ram_addr))
        else $error("read request longer than one cycle or address moved");

    a_wb_same_addr: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ram_wr_en |-> $past(ram_rd_en, 2) && ram_addr == $past(ram_addr, 2))
        else $error("write-back not at the address read two cycles before");

    a_flags_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_reg != ST_EXEC) |=> $stable(acc_reg) && $stable(cf_reg) && $stable(zf_reg))
        else $error("accumulator or flags changed outside execution");

    a_busy_refuse: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !instr_ready |=> !ram_rd_en)
        else $error("word taken while busy");

    a_drop_unknown: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (instr_ready && instr_valid && !dif.known) |=>
            instr_ready && !ram_rd_en && $stable(acc_reg))
        else $error("unknown word not dropped");

    a_no_wb_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_reg == ST_EXEC && !dif.writeback) |=> !ram_wr_en ##1 !ram_wr_en)
        else $error("load-only form wrote memory");

    a_done_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
        exec_done |=> !exec_done && instr_ready)
        else $error("completion pulse too long or unit not ready after it");

    a_wb_data: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ram_wr_en |-> ram_wdata == result_nibble_register)
        else $error("write-back data differs from accumulator");
endmodule

`default_nettype wire

// file: testbench.sv
// self-checking bench for the nibble addition unit
// assumes nau_unit, nau_decoder and the ram model are compiled before it
`default_nettype none
`include "nau_defs.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, sys_rst, instr_valid, instr_ready, ram_rd_en, ram_wr_en;
    logic carry_flag, zero_flag, exec_done;
    logic [15:0] instr_word;
    logic [6:0] ram_addr;
    logic [3:0] ram_rdata, ram_wdata, result_nibble_register;
    logic [3:0] shadow [0:127];
    logic [3:0] tb_acc;
    logic tb_cf, tb_zf;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;

    nau_unit dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_ready(instr_ready), .ram_addr(ram_addr),
        .ram_rd_en(ram_rd_en), .ram_rdata(ram_rdata), .ram_wr_en(ram_wr_en),
        .ram_wdata(ram_wdata), .result_nibble_register(result_nibble_register),
        .carry_flag(carry_flag), .zero_flag(zero_flag), .exec_done(exec_done));
    nau_ram_model ram (.clk_sys(clk_sys), .ram_addr(ram_addr), .ram_rd_en(ram_rd_en),
        .ram_rdata(ram_rdata), .ram_wr_en(ram_wr_en), .ram_wdata(ram_wdata));

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic poke(input logic [6:0] a, input logic [3:0] v);
        shadow[a] = v;
        ram.mem[a] = v;
    endtask

    // offer one word, take it, then judge timing, result, flags and ram effect
    task automatic run_op(input logic [7:0] op, input logic [7:0] lo, input bit hold);
        logic mem_form, wb, cin;
        logic [6:0] a;
        logic [4:0] sum;
        int n;
        mem_form = op inside {8'h10, 8'h09, 8'h18, 8'h19, 8'h28};
        wb = op inside {8'h09, 8'h0D, 8'h19, 8'h1D};
        cin = (op inside {8'h10, 8'h0C, 8'h09, 8'h0D}) ? tb_cf : 1'b0;
        a = mem_form ? lo[6:0] : `NAU_WR_BASE + {3'h0, lo[3:0]};
        sum = {1'b0, shadow[a]} + {1'b0, mem_form ? tb_acc : lo[7:4]} + {4'h0, cin};
        @(negedge clk_sys);
        instr_valid = 1'b1;
        instr_word = {op, lo};
        @(posedge clk_sys);
        @(negedge clk_sys);
        instr_valid = hold;
        instr_word = 16'h1D00;
        chk("rd_addr", {9'h0, ram_addr}, {9'h0, a});
        chk("rd_en", ram_rd_en, 1'b1);
        n = 1;
        while (exec_done !== 1'b1 && n < 6)
        begin
            @(negedge clk_sys);
            n++;
        end
        instr_valid = 1'b0;
        chk("done_cycle", n, 3);
        tb_acc = sum[3:0];
        tb_zf = (sum[3:0] == 4'h0);
        if (op != 8'h28)
            tb_cf = sum[4];
        chk("acc", result_nibble_register, tb_acc);
        chk("carry", carry_flag, tb_cf);
        chk("zero", zero_flag, tb_zf);
        chk("wr_en", ram_wr_en, wb);
        if (wb)
        begin
            chk("wr_addr", {9'h0, ram_addr}, {9'h0, a});
            chk("wr_data", ram_wdata, sum[3:0]);
            shadow[a] = sum[3:0];
        end
        @(negedge clk_sys);
        chk("ready", instr_ready, 1'b1);
        chk("ram", ram.mem[a], shadow[a]);
        chk("no_extra", exec_done, 1'b0);
    endtask

    // a word that must be taken and dropped with no effect
    task automatic drop_op(input logic [7:0] op, input logic [7:0] lo);
        @(negedge clk_sys);
        instr_valid = 1'b1;
        instr_word = {op, lo};
        @(negedge clk_sys);
        instr_valid = 1'b0;
        repeat (5)
        begin
            chk("drop_done", {ram_wr_en, exec_done, ram_rd_en}, 3'h0);
            chk("drop_ready", instr_ready, 1'b1);
            @(negedge clk_sys);
        end
        chk("drop_acc", {carry_flag, zero_flag, result_nibble_register},
            {tb_cf, tb_zf, tb_acc});
    endtask

    task automatic t_plain;
        poke(7'h7F, 4'hF);
        run_op(`NAU_OP_PLAIN_MEM_LOAD, 8'h7F, 0);
        poke(7'h20, 4'h1);
        run_op(`NAU_OP_PLAIN_MEM_WB, 8'h20, 0);
        poke(7'h03, 4'h9);
        run_op(`NAU_OP_PLAIN_IMM_LOAD, 8'h73, 0);
        run_op(`NAU_OP_PLAIN_IMM_WB, 8'hA3, 0);
    endtask

    task automatic t_carry_in;
        run_op(`NAU_OP_CIN_MEM_LOAD, 8'h20, 0);
        poke(7'h0F, 4'hE);
        run_op(`NAU_OP_CIN_IMM_LOAD, 8'h2F, 0);
        run_op(`NAU_OP_CIN_MEM_WB, 8'h7F, 0);
        run_op(`NAU_OP_CIN_IMM_WB, 8'hFF, 0);
        run_op(`NAU_OP_CIN_IMM_WB, 8'h10, 0);
    endtask

    task automatic t_keep_carry;
        poke(7'h11, ~tb_acc);
        run_op(`NAU_OP_PLAIN_MEM_LOAD, 8'h11, 0);
        poke(7'h12, 4'h1);
        run_op(`NAU_OP_KEEPC_MEM_LOAD, 8'h12, 0);
        poke(7'h13, 4'hF);
        run_op(`NAU_OP_PLAIN_MEM_LOAD, 8'h13, 0);
        run_op(`NAU_OP_PLAIN_MEM_LOAD, 8'h13, 0);
        poke(7'h14, 4'h2);
        run_op(`NAU_OP_KEEPC_MEM_LOAD, 8'h14, 0);
    endtask

    task automatic t_refuse_and_drop;
        poke(7'h40, 4'h6);
        run_op(`NAU_OP_PLAIN_MEM_WB, 8'h40, 1);
        drop_op(`NAU_OP_PLAIN_MEM_LOAD, 8'hC0);
        drop_op(8'h2C, 8'h11);
        drop_op(8'h00, 8'h00);
    endtask

    initial
    begin
        sys_rst = 1'b1;
        instr_valid = 1'b0;
        instr_word = 16'h0000;
        tb_acc = 4'h0;
        tb_cf = 1'b0;
        tb_zf = 1'b0;
        for (int i = 0; i < 128; i++)
            poke(i[6:0], i[3:0] ^ 4'h5);
        repeat (8) @(negedge clk_sys);
        sys_rst = 1'b0;
        chk("rst_out", {instr_ready, exec_done, ram_wr_en, carry_flag, zero_flag},
            5'h10);
        chk("rst_acc", result_nibble_register, 4'h0);
        chk("rst_rd", ram_rd_en, 1'b0);
        t_plain();
        t_carry_in();
        t_keep_carry();
        t_refuse_and_drop();
        wrap_up();
    end
endmodule

`default_nettype wire
